// ==== logic/dma_ch_pkg.sv ====
/*
  Shared constants for the USB device DMA channel control block.
  Assumes a 32-bit AXI4-Lite register bus with byte addresses.
*/
package dma_ch_pkg;
  // ==========================================================
  // Register map
  // ==========================================================
  localparam logic [11:0] CTRL_OFS = 12'h318;
  localparam logic [11:0] STAT_OFS = 12'h31c;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] STAT_RST = 32'h0000_0000;
  // ==========================================================
  // Control fields
  // ==========================================================
  localparam int LEN_LSB = 16;
  localparam int LOCK_BIT = 7;
  localparam int DLIE_BIT = 6;
  localparam int EOBIE_BIT = 5;
  localparam int EOTIE_BIT = 4;
  localparam int DEND_BIT = 3;
  localparam int BCI_BIT = 2;
  localparam int LDNXT_BIT = 1;
  localparam int CHANNEL_ENABLE_BIT = 0;
  // ==========================================================
  // Status fields
  // ==========================================================
  localparam int CNT_LSB = 16;
  localparam int DLF_BIT = 6;
  localparam int EOBF_BIT = 5;
  localparam int EOTF_BIT = 4;
  localparam int ACT_BIT = 1;
  localparam int STEN_BIT = 0;
  // Flag slots inside the flag unit.
  localparam int FL_EOT = 0;
  localparam int FL_EOB = 1;
  localparam int FL_DL = 2;
  localparam int NFLAG = 3;
  // ==========================================================
  // Bus answers and alignment
  // ==========================================================
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [16:0] FULL_LEN = 17'h1_0000;
  localparam logic [2:0] WORD_BYTES = 3'h4;
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DRAIN, ST_FETCH} chan_state_e;
endpackage : dma_ch_pkg

// ==== logic/dma_status_flags.sv ====
/*
  Sticky status flags of one DMA channel, cleared by a status read.
  Assumes set and clear arrive as one-cycle pulses on aclk.
*/
`timescale 1ns/1ns
module dma_status_flags
  import dma_ch_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  flag_if.unit fi
);
  logic [NFLAG-1:0] flag_ff;
  logic irq_ff;

  // ==========================================================
  // Flags
  // ==========================================================
  genvar i;
  generate
    for (i = 0; i < NFLAG; i++)
    begin : g_flag
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          flag_ff[i] <= 1'b0;
        else if (fi.set[i])
          flag_ff[i] <= 1'b1;
        else if (fi.clr[i])
          flag_ff[i] <= 1'b0;
      end
    end
  endgenerate

  // ==========================================================
  // Request
  // ==========================================================
  // flag and enable gate.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_ff <= 1'b0;
    else
      irq_ff <= |(flag_ff & fi.en);
  end

  assign fi.flags = flag_ff;
  assign fi.irq = irq_ff;
endmodule : dma_status_flags

// ==== logic/flag_if.sv ====
/*
  Carrier between the channel controller and its status flag unit.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ns
interface flag_if;
  logic [2:0] set;
  logic [2:0] clr;
  logic [2:0] en;
  logic [2:0] flags;
  logic irq;
  modport ctrl (output set, output clr, output en, input flags, input irq);
  modport unit (input set, input clr, input en, output flags, output irq);
endinterface : flag_if

// ==== logic/usb_dma_channel_ctrl.sv ====
/*
  Control and status logic of one USB device DMA channel, with an
  AXI4-Lite slave for its control and status registers.
  Assumes the endpoint, FIFO and system bus engine around it give
  one-cycle pulses on aclk and that chan_addr is the current bus address.
*/
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ns
// Function
// - Length field counts bytes; zero means 64kB.
// - Length writes and loads ignored while channel still enabled.
// - Burst lock only when burst lock enable is one.
// - Descriptor loaded interrupt gated by its enable.
// - End of buffer interrupt when remaining count reaches zero.
// - End of transfer interrupt only with buffer close on input.
// - IN endpoint: short packet sent at end of DMA buffer.
// - OUT endpoint: all banks released at end of DMA buffer.
// - Short OUT packet closes transfer when buffer close set.
// - Load next descriptor after transfer end when enabled.
// - Load-next and enable pair selects stop, run, load, link.
// - Enable zero with load-next zero freezes the channel.
// - Writing enable one sets channel enabled and starts transfer.
// - Enable bit clears at end of buffer.
// - Disable during service drains FIFO before clearing enabled.
// - Load-now skips descriptor, fetches next on endpoint request.
// - Remaining count decrements on every DMA access while running.
// - Descriptor loaded flag sets on load, clears on read.
// - End of buffer flag sets at zero count, clears on read.
// - End of transfer flag sets on close, clears on read.
// - Active while sourcing data; held across descriptor load.
// - Enabled sets one cycle after enable or load.
// - Descriptor fetch address is 16-byte aligned.
// - Word accesses, narrower at unaligned packet ends.
module usb_dma_channel_ctrl
  import dma_ch_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [ADDR_W-1:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  input wire logic ep_is_in,
  input wire logic ep_request,
  input wire logic usb_out_short_end,
  input wire logic fifo_empty,
  input wire logic dma_access,
  input wire logic [2:0] dma_bytes,
  input wire logic [31:0] chan_addr,
  input wire logic [31:0] next_desc_ptr,
  input wire logic desc_load_done,
  input wire logic [31:0] desc_control,
  output logic xfer_enable,
  output logic system_bus_lock,
  output logic [31:0] system_bus_addr,
  output logic [2:0] system_bus_bytes,
  output logic desc_fetch_req,
  output logic [31:0] desc_fetch_addr,
  output logic send_short_packet,
  output logic release_all_banks,
  output logic channel_irq
);
  // ==========================================================
  // Decoding helpers
  // ==========================================================
  function automatic logic [1:0] reg_sel(input logic [ADDR_W-1:0] a);
    if (a[11:0] == CTRL_OFS)
      return 2'h1;
    else if (a[11:0] == STAT_OFS)
      return 2'h2;
    else
      return 2'h0;
  endfunction : reg_sel

  function automatic logic [2:0] acc_width(input logic [1:0] lo,
                                           input logic [16:0] left);
    logic [2:0] room;
    room = WORD_BYTES - {1'b0, lo};
    if (left < {14'h0, room})
      return left[2:0];
    else
      return room;
  endfunction : acc_width

  // ==========================================================
  // State
  // ==========================================================
  flag_if fi ();
  chan_state_e state_ff;
  chan_state_e nxt_state;
  logic [15:0] channel_length_ff;
  logic burst_lock_enable_ff;
  logic descriptor_loaded_irq_enable_ff;
  logic end_of_buffer_irq_enable_ff;
  logic end_of_transfer_irq_enable_ff;
  logic end_of_dma_completion_enable_ff;
  logic buffer_close_on_input_ff;
  logic load_next_descriptor_ff;
  logic channel_enable_ff;
  logic status_enabled_ff;
  logic channel_active_ff;
  logic start_ff;
  logic [16:0] remaining_ff;
  logic aw_got_ff, w_got_ff;
  logic [ADDR_W-1:0] aw_addr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;
  logic lock_ff, fetch_ff, short_ff, release_ff, xfer_ff;
  logic [31:0] bus_addr_ff, desc_addr_ff;
  logic [2:0] bus_bytes_ff;
  logic aw_take, w_take, ar_take, wr_do, ctrl_wr, stat_rd;
  logic cnt_hit, short_end, end_xfer, stop_req, desc_in;
  logic nxt_aw_got, nxt_w_got, nxt_bvalid, nxt_rvalid;
  logic [31:0] ctrl_word, stat_word;

  // ==========================================================
  // Bus slave
  // ==========================================================
  always_comb
  begin
    aw_take = s_awvalid && awready_ff;
    w_take = s_wvalid && wready_ff;
    ar_take = s_arvalid && arready_ff;
    wr_do = aw_got_ff && w_got_ff && !bvalid_ff;
    ctrl_wr = wr_do && (reg_sel(aw_addr_ff) == 2'h1) && wstrb_ff[0];
    stat_rd = ar_take && (reg_sel(s_araddr) == 2'h2);
    nxt_aw_got = aw_take || (aw_got_ff && !wr_do);
    nxt_w_got = w_take || (w_got_ff && !wr_do);
    nxt_bvalid = wr_do || (bvalid_ff && !s_bready);
    nxt_rvalid = ar_take || (rvalid_ff && !s_rready);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      aw_addr_ff <= '0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end
    else
    begin
      aw_got_ff <= nxt_aw_got;
      w_got_ff <= nxt_w_got;
      awready_ff <= !nxt_aw_got && !nxt_bvalid;
      wready_ff <= !nxt_w_got && !nxt_bvalid;
      bvalid_ff <= nxt_bvalid;
      if (aw_take)
        aw_addr_ff <= s_awaddr;
      if (w_take)
      begin
        wdata_ff <= s_wdata;
        wstrb_ff <= s_wstrb;
      end
      if (wr_do)
        bresp_ff <= (reg_sel(aw_addr_ff) == 2'h0) ? RESP_SLVERR : RESP_OKAY;
    end
  end

  assign ctrl_word = {channel_length_ff, 8'h00, burst_lock_enable_ff,
                      descriptor_loaded_irq_enable_ff,
                      end_of_buffer_irq_enable_ff,
                      end_of_transfer_irq_enable_ff,
                      end_of_dma_completion_enable_ff,
                      buffer_close_on_input_ff, load_next_descriptor_ff,
                      channel_enable_ff};
  assign stat_word = {remaining_ff[15:0], 9'h000, fi.flags[FL_DL],
                      fi.flags[FL_EOB], fi.flags[FL_EOT], 2'h0,
                      channel_active_ff, status_enabled_ff};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= RESP_OKAY;
    end
    else
    begin
      arready_ff <= !nxt_rvalid;
      rvalid_ff <= nxt_rvalid;
      if (ar_take)
      begin
        if (reg_sel(s_araddr) == 2'h1)
        begin
          rdata_ff <= ctrl_word;
          rresp_ff <= RESP_OKAY;
        end
        else if (reg_sel(s_araddr) == 2'h2)
        begin
          rdata_ff <= stat_word;
          rresp_ff <= RESP_OKAY;
        end
        else
        begin
          rdata_ff <= 32'h0000_0000;
          rresp_ff <= RESP_SLVERR;
        end
      end
    end
  end

  // ==========================================================
  // Channel events
  // ==========================================================
  always_comb
  begin
    // count falls by the access width.
    cnt_hit = (state_ff == ST_RUN) && dma_access
              && (remaining_ff <= {14'h0, dma_bytes});
    // short OUT packet closes the buffer.
    short_end = (state_ff == ST_RUN) && usb_out_short_end
                && buffer_close_on_input_ff;
    end_xfer = cnt_hit || short_end;
    // disable while running goes through drain.
    stop_req = (state_ff == ST_RUN) && ctrl_wr && !wdata_ff[CHANNEL_ENABLE_BIT];
    desc_in = (state_ff == ST_FETCH) && desc_load_done;
  end

  // ==========================================================
  // Sequencer
  // ==========================================================
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:
      begin
        // enable alone runs, load-next alone loads now.
        if (start_ff)
          nxt_state = ST_RUN;
        // load-now waits for the endpoint request.
        else if (load_next_descriptor_ff && !channel_enable_ff && ep_request)
          nxt_state = ST_FETCH;
      end
      ST_RUN:
      begin
        // link to the next descriptor at end of buffer.
        if (end_xfer)
          nxt_state = load_next_descriptor_ff ? ST_FETCH : ST_IDLE;
        else if (stop_req)
          nxt_state = ST_DRAIN;
      end
      ST_DRAIN:
      begin
        if (fifo_empty)
          nxt_state = ST_IDLE;
      end
      ST_FETCH:
      begin
        if (desc_in)
          nxt_state = ST_IDLE;
      end
      default:
        nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state_ff <= ST_IDLE;
    else
      state_ff <= nxt_state;
  end

  // ==========================================================
  // Control register
  // ==========================================================
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      channel_length_ff <= CTRL_RST[31:LEN_LSB];
      burst_lock_enable_ff <= CTRL_RST[LOCK_BIT];
      descriptor_loaded_irq_enable_ff <= CTRL_RST[DLIE_BIT];
      end_of_buffer_irq_enable_ff <= CTRL_RST[EOBIE_BIT];
      end_of_transfer_irq_enable_ff <= CTRL_RST[EOTIE_BIT];
      end_of_dma_completion_enable_ff <= CTRL_RST[DEND_BIT];
      buffer_close_on_input_ff <= CTRL_RST[BCI_BIT];
      load_next_descriptor_ff <= CTRL_RST[LDNXT_BIT];
      channel_enable_ff <= CTRL_RST[CHANNEL_ENABLE_BIT];
    end
    else if (ctrl_wr || desc_in)
    begin
      // length only taken while the channel is disabled.
      if (!status_enabled_ff)
        channel_length_ff <= ctrl_wr ? wdata_ff[31:LEN_LSB]
                                     : desc_control[31:LEN_LSB];
      burst_lock_enable_ff <= ctrl_wr ? wdata_ff[LOCK_BIT] : desc_control[LOCK_BIT];
      descriptor_loaded_irq_enable_ff <= ctrl_wr ? wdata_ff[DLIE_BIT]
                                                 : desc_control[DLIE_BIT];
      end_of_buffer_irq_enable_ff <= ctrl_wr ? wdata_ff[EOBIE_BIT]
                                             : desc_control[EOBIE_BIT];
      end_of_transfer_irq_enable_ff <= ctrl_wr ? wdata_ff[EOTIE_BIT]
                                               : desc_control[EOTIE_BIT];
      end_of_dma_completion_enable_ff <= ctrl_wr ? wdata_ff[DEND_BIT]
                                                 : desc_control[DEND_BIT];
      buffer_close_on_input_ff <= ctrl_wr ? wdata_ff[BCI_BIT] : desc_control[BCI_BIT];
      load_next_descriptor_ff <= ctrl_wr ? wdata_ff[LDNXT_BIT]
                                         : desc_control[LDNXT_BIT];
      channel_enable_ff <= ctrl_wr ? wdata_ff[CHANNEL_ENABLE_BIT] : desc_control[CHANNEL_ENABLE_BIT];
    end
    // enable drops when the buffer ends.
    else if (end_xfer)
      channel_enable_ff <= 1'b0;
  end

  // ==========================================================
  // Status and count
  // ==========================================================
  // enable written one, or a descriptor that enables, starts.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      start_ff <= 1'b0;
    else
      start_ff <= (ctrl_wr && wdata_ff[CHANNEL_ENABLE_BIT] && state_ff == ST_IDLE)
                  || (desc_in && desc_control[CHANNEL_ENABLE_BIT]);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      status_enabled_ff <= STAT_RST[STEN_BIT];
    // set the cycle after the start request.
    else if (start_ff)
      status_enabled_ff <= 1'b1;
    // freeze at end of buffer, or after the FIFO has drained on a stop.
    else if (end_xfer || (state_ff == ST_DRAIN && fifo_empty))
      status_enabled_ff <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      remaining_ff <= {1'b0, STAT_RST[31:CNT_LSB]};
    // zero length stands for the full 64kB.
    else if (start_ff && remaining_ff == 17'h0_0000)
      remaining_ff <= (channel_length_ff == 16'h0000) ? FULL_LEN
                                                      : {1'b0, channel_length_ff};
    else if (short_end || cnt_hit)
      remaining_ff <= 17'h0_0000;
    else if (state_ff == ST_RUN && dma_access)
      remaining_ff <= remaining_ff - {14'h0, dma_bytes};
  end

  // active follows the endpoint request, held through a linked fetch.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      channel_active_ff <= STAT_RST[ACT_BIT];
    else if (state_ff == ST_RUN)
      channel_active_ff <= ep_request || (cnt_hit && load_next_descriptor_ff);
    else if (state_ff == ST_IDLE)
      channel_active_ff <= 1'b0;
  end

  // ==========================================================
  // Flag unit
  // ==========================================================
  // end of buffer at zero count, close by USB.
  assign fi.set = {desc_in, cnt_hit, short_end};
  assign fi.clr = {NFLAG{stat_rd}};
  assign fi.en = {descriptor_loaded_irq_enable_ff, end_of_buffer_irq_enable_ff,
                  end_of_transfer_irq_enable_ff && buffer_close_on_input_ff};

  dma_status_flags u_flags (
    .aclk(aclk),
    .aresetn(aresetn),
    .fi(fi.unit)
  );

  // ==========================================================
  // Engine side outputs
  // ==========================================================
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lock_ff <= 1'b0;
      fetch_ff <= 1'b0;
      short_ff <= 1'b0;
      release_ff <= 1'b0;
      xfer_ff <= 1'b0;
      bus_addr_ff <= 32'h0000_0000;
      bus_bytes_ff <= 3'h0;
      desc_addr_ff <= 32'h0000_0000;
    end
    else
    begin
      xfer_ff <= (nxt_state == ST_RUN) && !stop_req;
      // lock only bursts of an enabled lock.
      lock_ff <= burst_lock_enable_ff && (state_ff == ST_RUN) && ep_request;
      fetch_ff <= (nxt_state == ST_FETCH);
      // IN endpoint closes with a short packet.
      short_ff <= cnt_hit && end_of_dma_completion_enable_ff && ep_is_in;
      release_ff <= end_xfer && end_of_dma_completion_enable_ff && !ep_is_in;
      // word address, width trimmed at packet ends.
      bus_addr_ff <= {chan_addr[31:2], 2'b00};
      bus_bytes_ff <= acc_width(chan_addr[1:0], remaining_ff);
      desc_addr_ff <= {next_desc_ptr[31:4], 4'h0};
    end
  end

  assign s_awready = awready_ff;
  assign s_wready = wready_ff;
  assign s_bvalid = bvalid_ff;
  assign s_bresp = bresp_ff;
  assign s_arready = arready_ff;
  assign s_rvalid = rvalid_ff;
  assign s_rdata = rdata_ff;
  assign s_rresp = rresp_ff;
  assign xfer_enable = xfer_ff;
  assign system_bus_lock = lock_ff;
  assign system_bus_addr = bus_addr_ff;
  assign system_bus_bytes = bus_bytes_ff;
  assign desc_fetch_req = fetch_ff;
  assign desc_fetch_addr = desc_addr_ff;
  assign send_short_packet = short_ff;
  assign release_all_banks = release_ff;
  assign channel_irq = fi.irq;
endmodule : usb_dma_channel_ctrl

// ==== tb/dma_ch_checker.sv ====
/* Port assertions for one USB device DMA channel controller.
   Assumes it is bound into usb_dma_channel_ctrl. */
`timescale 1ns/1ns
module dma_ch_checker
  import dma_ch_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_araddr,
  input wire logic s_arvalid,
  input wire logic s_arready,
  input wire logic s_rvalid,
  input wire logic s_bvalid,
  input wire logic ep_is_in,
  input wire logic usb_out_short_end,
  input wire logic dma_access,
  input wire logic [31:0] chan_addr,
  input wire logic [31:0] next_desc_ptr,
  input wire logic desc_load_done,
  input wire logic xfer_enable,
  input wire logic [31:0] system_bus_addr,
  input wire logic [2:0] system_bus_bytes,
  input wire logic desc_fetch_req,
  input wire logic [31:0] desc_fetch_addr,
  input wire logic send_short_packet,
  input wire logic release_all_banks,
  input wire logic channel_irq
);
  default clocking dcb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_bus_addr; system_bus_addr == {$past(chan_addr[31:2]), 2'h0}; endproperty
  a_bus_addr: assert property (p_bus_addr) else $error("Bad bus address.");
  property p_bus_bytes; {1'h0, system_bus_bytes} + {2'h0, $past(chan_addr[1:0])} <= 4'h4; endproperty
  a_bus_bytes: assert property (p_bus_bytes) else $error("Bad access width.");
  property p_desc_addr;
    desc_fetch_req |-> desc_fetch_addr == {$past(next_desc_ptr[31:4]), 4'h0};
  endproperty
  a_desc_addr: assert property (p_desc_addr) else $error("Bad fetch address.");
  property p_short_in; send_short_packet |-> $past(ep_is_in); endproperty
  a_short_in: assert property (p_short_in) else $error("Short packet on OUT.");
  property p_rel_out; release_all_banks |-> !$past(ep_is_in); endproperty
  a_rel_out: assert property (p_rel_out) else $error("Bank release on IN.");
  property p_en_src;
    $rose(xfer_enable) |-> $past(s_bvalid) || $past(s_bvalid, 2) || $past(desc_load_done)
      || $past(desc_load_done, 2) || $past(desc_load_done, 3);
  endproperty
  a_en_src: assert property (p_en_src) else $error("Enable without cause.");
  property p_irq_clr;
    s_arvalid && s_arready && s_araddr == STAT_OFS && !dma_access && !desc_load_done
      && !usb_out_short_end |=> ##1 !channel_irq;
  endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("Irq after read.");
  property p_rd_ans; s_arvalid && s_arready |=> s_rvalid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("Late read answer.");
  c_short: cover property (send_short_packet);
  c_rel: cover property (release_all_banks);
  c_load: cover property (desc_load_done ##[1:4] xfer_enable);
endmodule : dma_ch_checker
bind usb_dma_channel_ctrl dma_ch_checker #(.ADDR_W(ADDR_W)) chk (.*);

// ==== tb/dma_far_side.sv ====
/* Far side of one DMA channel: descriptor memory and the channel FIFO.
   Assumes the bench hands it the next descriptor word. */
`timescale 1ns/1ns
module dma_far_side
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic desc_fetch_req,
  input wire logic fifo_load,
  input wire logic [31:0] next_word,
  output logic fifo_empty,
  output logic desc_load_done,
  output logic [31:0] desc_control
);
  logic [3:0] level_ff;
  logic [2:0] wait_ff;
  logic slow_ff;
  logic done_ff;
  logic take;
  logic [31:0] word_ff;
  assign fifo_empty = (level_ff == 4'h0);
  assign desc_load_done = done_ff;
  assign desc_control = word_ff;
  assign take = aresetn && desc_fetch_req && wait_ff == 3'h4;
  // The FIFO drains one word every second cycle, so a stop must wait.
  always_ff @(posedge aclk)
  begin
    slow_ff <= aresetn & ~slow_ff;
    if (!aresetn)
      level_ff <= 4'h0;
    else if (fifo_load)
      level_ff <= 4'h8;
    else if (slow_ff && level_ff != 4'h0)
      level_ff <= level_ff - 4'h1;
  end
  // The word toggles outside a load so a stale value is never mistaken.
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !desc_fetch_req)
      wait_ff <= 3'h0;
    else if (wait_ff != 3'h7)
      wait_ff <= wait_ff + 3'h1;
    done_ff <= take;
    word_ff <= take ? next_word : (aresetn ? ~word_ff : 32'h0000_0000);
  end
endmodule : dma_far_side

// ==== tb/tb_usb_device_dma_channel_ctrl.sv ====
/* Self-checking bench for one USB device DMA channel controller.
   Assumes dma_far_side and the bound checker. */
`timescale 1ns/1ns
module tb_usb_device_dma_channel_ctrl
  import dma_ch_pkg::*;
;
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_total++; \
  $display("[ERR] %0t %h %h", $time, a, b); end end
  logic aclk = 1'h0, aresetn = 1'h0, s_awvalid = 1'h0, s_wvalid = 1'h0, s_bready = 1'h0;
  logic s_arvalid = 1'h0, s_rready = 1'h0, ep_is_in = 1'h1, ep_request = 1'h0;
  logic usb_out_short_end = 1'h0, dma_access = 1'h0, fifo_load = 1'h0;
  logic [11:0] s_awaddr = 12'h000, s_araddr = 12'h000;
  logic [31:0] s_wdata = 32'h0000_0000, chan_addr = 32'h0000_0000, next_word = 32'h0004_0041;
  logic [31:0] next_desc_ptr = 32'h0000_1234, s_rdata, desc_control, system_bus_addr;
  logic [31:0] desc_fetch_addr, rv;
  logic [3:0] s_wstrb = 4'hf;
  logic [2:0] dma_bytes = 3'h4, system_bus_bytes;
  logic [1:0] s_bresp, s_rresp, rr;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, fifo_empty, desc_load_done;
  logic xfer_enable, system_bus_lock, desc_fetch_req, send_short_packet, release_all_banks;
  logic channel_irq, seen_ssp = 1'h0, seen_rel = 1'h0, seen_lock = 1'h0;
  int err_total = 0;
  int n_compared = 0;
  wire [2:0] obs = {desc_fetch_req, channel_irq, xfer_enable};
  always #2 aclk = ~aclk;
  always @(posedge aclk)
  begin
    seen_ssp <= seen_ssp | (send_short_packet === 1'h1);
    seen_rel <= seen_rel | (release_all_banks === 1'h1);
    seen_lock <= seen_lock | (system_bus_lock === 1'h1);
  end
  usb_dma_channel_ctrl #(.ADDR_W(12)) uut (.*);
  dma_far_side far (.*);
  task automatic conclude;
    if (err_total == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : conclude
  task automatic hang(input int n, input int lim);
    if (n >= lim)
    begin
      `CHK(n, 0)
      conclude();
    end
  endtask : hang
  task automatic wt(input int b, input logic v);
    int n;
    n = 0;
    while (obs[b] !== v && n < 500)
    begin
      @(posedge aclk);
      n++;
    end
    hang(n, 500);
  endtask : wt
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'h1;
    s_wvalid <= 1'h1;
    s_bready <= 1'h1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_awready === 1'h1) s_awvalid <= 1'h0;
      if (s_wready === 1'h1) s_wvalid <= 1'h0;
    end
    while (s_bvalid !== 1'h1 && n < 100);
    rr = s_bresp;
    s_bready <= 1'h0;
    hang(n, 100);
  endtask : wr
  task automatic rd(input logic [11:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'h1;
    s_rready <= 1'h1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_arready === 1'h1) s_arvalid <= 1'h0;
    end
    while (s_rvalid !== 1'h1 && n < 100);
    rv = s_rdata;
    rr = s_rresp;
    s_rready <= 1'h0;
    hang(n, 100);
  endtask : rd
  task automatic acc(input logic [31:0] a);
    @(posedge aclk);
    chan_addr <= a;
    dma_access <= 1'h1;
    @(posedge aclk);
    dma_access <= 1'h0;
  endtask : acc
  task automatic t_regs;
    rd(CTRL_OFS);
    `CHK(rv, CTRL_RST)
    rd(STAT_OFS);
    `CHK(rv, STAT_RST)
    rd(12'h320);
    `CHK(rr, RESP_SLVERR)
    wr(12'h320, 32'h0000_0001);
    `CHK(rr, RESP_SLVERR)
  endtask : t_regs
  task automatic t_eob;
    wr(CTRL_OFS, 32'h0008_0029);
    wt(0, 1'h1);
    acc(32'h0000_0100);
    rd(STAT_OFS);
    `CHK(rv[31:16], 16'h0004)
    acc(32'h0000_0104);
    wt(0, 1'h0);
    wt(1, 1'h1);
    `CHK(seen_ssp, 1'h1)
    rd(CTRL_OFS);
    `CHK(rv[0], 1'h0)
    rd(STAT_OFS);
    `CHK({rv[5], rv[0]}, 2'h2)
    wt(1, 1'h0);
    rd(STAT_OFS);
    `CHK(rv[5], 1'h0)
    `CHK(seen_lock, 1'h0)
  endtask : t_eob
  task automatic t_drain;
    wr(CTRL_OFS, 32'h0010_0001);
    wt(0, 1'h1);
    fifo_load <= 1'h1;
    @(posedge aclk);
    fifo_load <= 1'h0;
    wr(CTRL_OFS, 32'h0004_0000);
    rd(STAT_OFS);
    `CHK(rv[0], 1'h1)
    repeat (20) @(posedge aclk);
    `CHK(fifo_empty, 1'h1)
    rd(STAT_OFS);
    `CHK(rv[1:0], 2'h0)
    rd(CTRL_OFS);
    `CHK(rv[31:16], 16'h0010)
  endtask : t_drain
  task automatic t_desc;
    ep_request <= 1'h1;
    wr(CTRL_OFS, 32'h0000_0042);
    wt(2, 1'h1);
    `CHK(desc_fetch_addr, 32'h0000_1230)
    wt(0, 1'h1);
    wt(1, 1'h1);
    rd(STAT_OFS);
    `CHK({rv[6], rv[0]}, 2'h3)
    rd(CTRL_OFS);
    `CHK(rv[31:16], 16'h0004)
    repeat (4) acc(32'h0000_0200);
    wt(0, 1'h0);
    rd(STAT_OFS);
    `CHK(rv[6:5], 2'h1)
  endtask : t_desc
  task automatic t_out;
    ep_is_in <= 1'h0;
    wr(CTRL_OFS, 32'h0000_009d);
    wt(0, 1'h1);
    acc(32'h0000_0301);
    rd(STAT_OFS);
    `CHK(rv[31:16], 16'hfffc)
    `CHK(seen_lock, 1'h1)
    usb_out_short_end <= 1'h1;
    @(posedge aclk);
    usb_out_short_end <= 1'h0;
    wt(0, 1'h0);
    wt(1, 1'h1);
    `CHK(seen_rel, 1'h1)
    rd(STAT_OFS);
    `CHK({rv[31:16], rv[4]}, 17'h0_0001)
  endtask : t_out
  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    t_regs();
    t_eob();
    t_drain();
    t_desc();
    t_out();
    conclude();
  end
endmodule : tb_usb_device_dma_channel_ctrl
